// >>> rml_regs.svh
/*
  Register offsets, field positions, reset values and timing counts of
  the strap latch. Included by the latch and the strap synchroniser.
*/
`ifndef RML_REGS_SVH
`define RML_REGS_SVH

`define RML_ADDR_MODE 8'h00
`define RML_ADDR_MISC 8'h01
`define RML_ADDR_STAT 8'h02

`define RML_MODE_LSB 0
`define RML_MODE_MSB 2
`define RML_MISC_FLASH_BIT 0
`define RML_STAT_DBG_BIT 0
`define RML_STAT_OSC_BIT 1
`define RML_STAT_CAP_BIT 2
`define RML_STAT_EXP_BIT 3

`define RML_PIN_MODE_LSB 0
`define RML_PIN_MODE_MSB 2
`define RML_PIN_FLASH 3
`define RML_PIN_OSC 4
`define RML_PIN_COUNT 5

`define RML_MODE_RST 3'h0
`define RML_FLASH_RST 1'b0
`define RML_OE_N_RST 1'b1

`define RML_SYNC_STAGES 3

`endif

// >>> rml_pkg.sv
/*
  Types and decode functions of the strap latch.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rml_pkg;

  typedef enum logic [2:0] {
    RML_SPECIAL_SINGLE = 3'b000,
    RML_EMUL_NARROW = 3'b001,
    RML_SPECIAL_TEST = 3'b010,
    RML_EMUL_WIDE = 3'b011,
    RML_NORMAL_SINGLE = 3'b100,
    RML_NORMAL_NARROW = 3'b101,
    RML_SPECIAL_PERIPH = 3'b110,
    RML_NORMAL_WIDE = 3'b111
  } rml_mode_t;

  typedef struct packed {
    logic captured;
    rml_mode_t mode;
    logic flash_vis;
    logic dbg_active;
    logic osc_lvl;
    logic alt_osc;
    logic cs_n;
    logic cs_oe_n;
    logic [7:0] rdata;
  } rml_state_t;

  function automatic logic rml_is_expanded(input rml_mode_t m);
    rml_is_expanded = (m != RML_SPECIAL_SINGLE) && (m != RML_NORMAL_SINGLE) &&
                      (m != RML_SPECIAL_PERIPH);
  endfunction : rml_is_expanded

  function automatic logic rml_flash_for(input rml_mode_t m, input logic strap);
    unique case (m)
      RML_SPECIAL_SINGLE, RML_NORMAL_SINGLE, RML_SPECIAL_PERIPH: rml_flash_for = 1'b1;
      RML_EMUL_NARROW, RML_SPECIAL_TEST, RML_EMUL_WIDE: rml_flash_for = 1'b0;
      RML_NORMAL_NARROW, RML_NORMAL_WIDE: rml_flash_for = strap;
    endcase
  endfunction : rml_flash_for

  // Only modes 000 to 011 may move, and never into the peripheral mode
  function automatic logic rml_mode_write_ok(input rml_mode_t cur, input rml_mode_t nxt);
    rml_mode_write_ok = !cur[2] && (nxt != RML_SPECIAL_PERIPH);
  endfunction : rml_mode_write_ok

endpackage : rml_pkg

// >>> rml_strap_if.sv
/*
  Carries filtered strap levels from the synchroniser to the latch.
  Assumes both ends run on core_clk.
*/
`timescale 1ns/100ps
interface rml_strap_if #(parameter int W = 5);
  logic [W-1:0] level;
  modport src (output level);
  modport dst (input level);
endinterface : rml_strap_if

// >>> rml_strap_sync.sv
/*
  Three-stage synchroniser with agreement filter for the strap pins.
  Assumes pins are asynchronous to core_clk; its flops carry no reset so
  that the straps keep being sampled while the chip is held in reset.
*/
`timescale 1ns/100ps
`include "rml_regs.svh"
module rml_strap_sync #(
  parameter int W = `RML_PIN_COUNT
) (
  // Clock
  input wire logic core_clk,
  // Raw pins
  input wire logic [W-1:0] pins,
  // Filtered levels
  rml_strap_if.src strap
);
  import rml_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] filt;
  } rml_sync_state_t;

  rml_sync_state_t st_q;
  rml_sync_state_t st_d;
  logic [W-1:0] agree;

  always_comb begin
    st_d = st_q;
    st_d.s1 = pins;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // A change counts only once the second and third stage agree
    agree = ~(st_q.s2 ^ st_q.s3);
    st_d.filt = (agree & st_q.s3) | (~agree & st_q.filt);
  end

  // No reset: sampling must go on during reset
  always_ff @(posedge core_clk) begin
    st_q <= st_d;
  end

  assign strap.level = st_q.filt;

  filter_follow_a: assert property (@(posedge core_clk)
    (st_q.s2 == st_q.s3) |=> (st_q.filt == $past(st_q.s3)))
    else $error("Filter did not follow agreeing stages");

endmodule : rml_strap_sync

// >>> rml_strap_latch.sv
/*
  Reset mode strap latch: catches the operating mode, flash visibility and
  oscillator type from the straps at reset release, keeps the debug-active
  and freeze state, drives the emulation chip select pin in expanded modes
  and offers a small register port.
  Assumes straps are held stable by the board around reset release and
  that the debug serial logic sends one-cycle activate/release pulses.
*/
// Our own choices: the plain strobed port and the address map.
// Operation
// - Latch three mode straps at reset release
// - Latch flash strap into flash visible bit
// - Flash visible bit maps flash in
// - Mode 000: special single, flash on, debug active
// - Other modes: debug waits for serial command
// - Mode 001: emulation narrow, flash off
// - Mode 010: special test wide, flash off
// - Mode 011: emulation wide, flash off
// - Mode 100: normal single, flash on
// - Mode 101: normal narrow, flash follows strap
// - Mode 111: normal wide, flash follows strap
// - Software mode changes only restricted transitions
// - Oscillator strap high selects Colpitts
// - Oscillator strap seen active low by clocking
// - Freeze outputs follow debug active exactly
// - Debug alternate clock is oscillator clock
// - Flash strap pin drives chip select when expanded
`timescale 1ns/100ps
`include "rml_regs.svh"
module rml_strap_latch (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Strap pins
  input wire logic mode_strap_2,
  input wire logic mode_strap_1,
  input wire logic mode_strap_0,
  input wire logic flash_map_strap,
  input wire logic osc_type_select,
  // Debug serial logic
  input wire logic dbg_activate,
  input wire logic dbg_release,
  input wire logic dbg_alt_clk_req,
  // Emulation chip select on the flash strap pin
  input wire logic cs_req_n,
  output logic emulation_chip_select_n,
  output logic port_k_pin7_oe_n,
  // Configuration outputs
  output rml_pkg::rml_mode_t operating_mode,
  output logic flash_visible,
  output logic config_valid,
  output logic background_debug_active,
  output logic freeze_timer,
  output logic freeze_conv0,
  output logic freeze_conv1,
  output logic osc_colpitts_sel,
  output logic osc_pierce_sel_n,
  output logic debug_clk_is_osc,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  import rml_pkg::*;

  rml_strap_if #(.W(`RML_PIN_COUNT)) straps ();

  rml_strap_sync #(.W(`RML_PIN_COUNT)) u_sync (
    .core_clk (core_clk),
    .pins ({osc_type_select, flash_map_strap, mode_strap_2, mode_strap_1, mode_strap_0}),
    .strap (straps)
  );

  rml_state_t st_q;
  rml_state_t st_d;
  rml_mode_t pin_mode;
  rml_mode_t wr_mode;
  logic mode_wr;

  assign pin_mode = rml_mode_t'(straps.level[`RML_PIN_MODE_MSB:`RML_PIN_MODE_LSB]);
  assign wr_mode = rml_mode_t'(reg_wdata[`RML_MODE_MSB:`RML_MODE_LSB]);
  assign mode_wr = reg_wr && (reg_addr == `RML_ADDR_MODE);

  always_comb begin
    st_d = st_q;
    st_d.rdata = 8'h00;
    if (!st_q.captured) begin
      // First edge after release: the filtered straps become the setup
      st_d.captured = 1'b1;
      st_d.mode = pin_mode;
      // Per-mode overrides of the flash strap
      st_d.flash_vis = rml_flash_for(pin_mode, straps.level[`RML_PIN_FLASH]);
      st_d.dbg_active = (pin_mode == RML_SPECIAL_SINGLE);
      st_d.osc_lvl = straps.level[`RML_PIN_OSC];
    end else begin
      // Mode 110 is left to the board; software cannot reach it
      if (mode_wr && rml_mode_write_ok(st_q.mode, wr_mode)) begin
        st_d.mode = wr_mode;
      end
      // Activation wins over a release in the same cycle
      if (dbg_release) begin
        st_d.dbg_active = 1'b0;
      end
      if (dbg_activate) begin
        st_d.dbg_active = 1'b1;
      end
      st_d.alt_osc = st_d.dbg_active && dbg_alt_clk_req;
      st_d.cs_oe_n = !rml_is_expanded(st_q.mode);
      st_d.cs_n = rml_is_expanded(st_q.mode) ? cs_req_n : 1'b1;
    end
    if (reg_rd) begin
      case (reg_addr)
        `RML_ADDR_MODE: st_d.rdata[`RML_MODE_MSB:`RML_MODE_LSB] = st_q.mode;
        `RML_ADDR_MISC: st_d.rdata[`RML_MISC_FLASH_BIT] = st_q.flash_vis;
        `RML_ADDR_STAT: begin
          st_d.rdata[`RML_STAT_DBG_BIT] = st_q.dbg_active;
          st_d.rdata[`RML_STAT_OSC_BIT] = st_q.osc_lvl;
          st_d.rdata[`RML_STAT_CAP_BIT] = st_q.captured;
          st_d.rdata[`RML_STAT_EXP_BIT] = rml_is_expanded(st_q.mode);
        end
        default: st_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q.captured <= 1'b0;
      st_q.mode <= rml_mode_t'(`RML_MODE_RST);
      st_q.flash_vis <= `RML_FLASH_RST;
      st_q.dbg_active <= 1'b0;
      st_q.osc_lvl <= 1'b0;
      st_q.alt_osc <= 1'b0;
      st_q.cs_n <= 1'b1;
      st_q.cs_oe_n <= `RML_OE_N_RST;
      st_q.rdata <= 8'h00;
    end else begin
      st_q <= st_d;
    end
  end

  assign operating_mode = st_q.mode;
  assign flash_visible = st_q.flash_vis;
  assign config_valid = st_q.captured;
  assign background_debug_active = st_q.dbg_active;
  // Freeze is the debug-active flop itself, so it cannot lag or lead
  assign freeze_timer = st_q.dbg_active;
  assign freeze_conv0 = st_q.dbg_active;
  assign freeze_conv1 = st_q.dbg_active;
  assign osc_colpitts_sel = st_q.osc_lvl;
  // Low level selects Pierce or external clock
  assign osc_pierce_sel_n = st_q.osc_lvl;
  assign debug_clk_is_osc = st_q.alt_osc;
  assign emulation_chip_select_n = st_q.cs_n;
  assign port_k_pin7_oe_n = st_q.cs_oe_n;
  assign reg_rdata = st_q.rdata;

  capture_mode_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(st_q.captured) |-> (st_q.mode == $past(straps.level[2:0])))
    else $error("Mode not taken from straps at release");

  special_single_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    ($rose(st_q.captured) && st_q.mode == RML_SPECIAL_SINGLE) |->
      (st_q.flash_vis && st_q.dbg_active))
    else $error("Special single chip did not force flash and debug");

  debug_idle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    ($rose(st_q.captured) && st_q.mode != RML_SPECIAL_SINGLE) |-> !st_q.dbg_active)
    else $error("Debug active without a command");

  flash_forced_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(st_q.captured) |->
      (st_q.flash_vis == rml_flash_for(st_q.mode, $past(straps.level[3]))))
    else $error("Flash visible bit wrong for mode");

  flash_follow_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    ($rose(st_q.captured) && st_q.mode[2] && st_q.mode[0]) |->
      (st_q.flash_vis == $past(straps.level[3])))
    else $error("Flash visible bit ignored strap in normal expanded");

  flash_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    st_q.captured |=> ($stable(st_q.flash_vis) && $stable(st_q.osc_lvl)))
    else $error("Latched strap value changed after capture");

  normal_locked_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_q.captured && st_q.mode[2]) |=> $stable(st_q.mode))
    else $error("Normal mode changed after reset");

  mode_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_q.captured && mode_wr && !st_q.mode[2] && wr_mode != RML_SPECIAL_PERIPH) |=>
      (st_q.mode == $past(wr_mode)))
    else $error("Permitted mode write not taken");

  debug_cmd_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_q.captured && dbg_activate) |=> st_q.dbg_active ##0 freeze_conv1)
    else $error("Debug command did not activate debug and freeze");

  chip_drive_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_q.captured && rml_is_expanded(st_q.mode)) |=>
      (!port_k_pin7_oe_n && emulation_chip_select_n == $past(cs_req_n)))
    else $error("Chip select not driven in expanded mode");

  alt_clock_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    debug_clk_is_osc |-> background_debug_active)
    else $error("Oscillator clock chosen outside debug");

  read_mode_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == `RML_ADDR_MODE) |=> (reg_rdata == {5'h00, $past(st_q.mode)}))
    else $error("Mode register read wrong");

  read_misc_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == `RML_ADDR_MISC) |=>
      (reg_rdata == {7'h00, $past(st_q.flash_vis)}))
    else $error("Flash visible read wrong");

  read_stat_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_rd && reg_addr == `RML_ADDR_STAT) |=>
      (reg_rdata == {4'h0, $past(rml_is_expanded(st_q.mode)), $past(st_q.captured),
                     $past(st_q.osc_lvl), $past(st_q.dbg_active)}))
    else $error("Status read wrong");

  read_unmapped_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (reg_rd && reg_addr > `RML_ADDR_STAT) |=> (reg_rdata == 8'h00))
    else $error("Unmapped address read not zero");

  rdata_idle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !reg_rd |=> (reg_rdata == 8'h00))
    else $error("Read data stood without a read");

  // Reset itself is the antecedent, so this one has no disable clause
  reset_quiet_a: assert property (@(posedge core_clk)
    sys_rst |-> (!config_valid && !background_debug_active && !freeze_timer &&
      port_k_pin7_oe_n && emulation_chip_select_n && (reg_rdata == 8'h00)))
    else $error("Outputs not at reset values during reset");

  captured_stays_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    st_q.captured |=> st_q.captured)
    else $error("Capture flag dropped without reset");

  osc_capture_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(st_q.captured) |-> (osc_colpitts_sel == $past(straps.level[`RML_PIN_OSC]) &&
      osc_pierce_sel_n == $past(straps.level[`RML_PIN_OSC])))
    else $error("Oscillator strap not taken at release");

  // One capture check per strap code; codes 5 and 7 expect the flash strap, the rest a fixed value
  for (genvar m = 0; m < 8; m++) begin : g_flash_code
    localparam logic [2:0] CODE = 3'(m);
    localparam logic FORCED = (m == 0) || (m == 4) || (m == 6);
    localparam logic FOLLOWS = (m == 5) || (m == 7);
    flash_code_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      ($rose(st_q.captured) && st_q.mode == CODE) |->
        (st_q.flash_vis == (FOLLOWS ? $past(straps.level[`RML_PIN_FLASH]) : FORCED)))
      else $error("Flash visible bit wrong for strap code");
  end : g_flash_code

  release_clears_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_q.captured && dbg_release && !dbg_activate) |=> !background_debug_active)
    else $error("Debug release not taken");

  debug_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_q.captured && !dbg_activate && !dbg_release) |=> $stable(background_debug_active))
    else $error("Debug state moved without a command");

  alt_clock_on_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_q.captured && st_q.dbg_active && dbg_alt_clk_req && !dbg_release) |=>
      debug_clk_is_osc)
    else $error("Oscillator clock not given to debug");

  alt_clock_off_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !dbg_alt_clk_req |=> !debug_clk_is_osc)
    else $error("Oscillator clock given without request");

  mode_refused_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_q.captured && mode_wr && (st_q.mode[2] || wr_mode == RML_SPECIAL_PERIPH)) |=>
      $stable(st_q.mode))
    else $error("Refused mode write was taken");

  mode_quiet_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_q.captured && !mode_wr) |=> $stable(st_q.mode))
    else $error("Mode moved without a write");

  chip_idle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (st_q.captured && !rml_is_expanded(st_q.mode)) |=>
      (port_k_pin7_oe_n && emulation_chip_select_n))
    else $error("Chip select pin driven outside expanded modes");

endmodule : rml_strap_latch

// >>> rml_board_model.sv
/*
  Board side of the strap latch: strap resistors and the shared pin that
  carries the flash strap in reset and, in expanded modes, the emulation chip select after it.
  Assumes the bench sets the strap levels and drives reset itself.
*/
`timescale 1ns/100ps
module rml_board_model (
  // Strap levels asked for by the bench
  input wire logic [2:0] code,
  input wire logic flash_lvl,
  input wire logic osc_lvl,
  // Chip select driven back onto the flash strap pin
  input wire logic cs_n,
  input wire logic cs_oe_n,
  // Pins
  output logic [2:0] mode_pins,
  output logic flash_pin,
  output logic osc_pin
);
  // Peripheral mode would fight the bus, so a real board never straps it
  assign mode_pins = (code == 3'h6) ? 3'h7 : code;
  // Once driven, the pin shows chip select and hides the strap resistor
  assign flash_pin = cs_oe_n ? flash_lvl : cs_n;
  assign osc_pin = osc_lvl;
endmodule : rml_board_model

// >>> tb.sv
/*
  Self-checking bench of the strap latch: resets under every strap code but 6,
  then register port, debug commands, mode writes and chip select.
  Assumes the board model supplies the strap pins.
*/
`timescale 1ns/100ps
module tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b0;
  logic [2:0] code = 3'h0;
  logic fl = 1'b0, osc = 1'b0, act = 1'b0, rel = 1'b0, alt = 1'b0, cs_req_n = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  logic wr = 1'b0, rd = 1'b0;
  logic [2:0] mp, cur, t;
  logic fp, op, cs_n, oe_n, fv, cv, dbg, fz_t, fz_0, fz_1, col, pie_n, dco, f0, x;
  logic [7:0] rdata;
  rml_pkg::rml_mode_t mode;
  int err_total = 0;
  int cmp_count = 0;

  always #5 core_clk = ~core_clk;

  rml_board_model u_rml_board_model (.code(code), .flash_lvl(fl), .osc_lvl(osc),
    .cs_n(cs_n), .cs_oe_n(oe_n), .mode_pins(mp), .flash_pin(fp), .osc_pin(op));
  rml_strap_latch u_rml_strap_latch (.core_clk(core_clk), .sys_rst(sys_rst),
    .mode_strap_2(mp[2]), .mode_strap_1(mp[1]), .mode_strap_0(mp[0]), .flash_map_strap(fp),
    .osc_type_select(op), .dbg_activate(act), .dbg_release(rel), .dbg_alt_clk_req(alt),
    .cs_req_n(cs_req_n), .emulation_chip_select_n(cs_n), .port_k_pin7_oe_n(oe_n),
    .operating_mode(mode), .flash_visible(fv), .config_valid(cv),
    .background_debug_active(dbg), .freeze_timer(fz_t), .freeze_conv0(fz_0),
    .freeze_conv1(fz_1), .osc_colpitts_sel(col), .osc_pierce_sel_n(pie_n),
    .debug_clk_is_osc(dco), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata));

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_byte

  // Sample just past the edge so its updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    cmp_byte(rdata, exp);
  endtask : rd_reg

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic dbg_cmd(input logic on);
    @(posedge core_clk);
    act <= on;
    rel <= !on;
    @(posedge core_clk);
    act <= 1'b0;
    rel <= 1'b0;
    #1;
  endtask : dbg_cmd

  function automatic logic exp_flash(input logic [2:0] c, input logic f);
    case (c)
      3'h0, 3'h4, 3'h6: exp_flash = 1'b1;
      3'h1, 3'h2, 3'h3: exp_flash = 1'b0;
      default: exp_flash = f;
    endcase
  endfunction : exp_flash

  function automatic logic expanded(input logic [2:0] c);
    expanded = !(c == 3'h0 || c == 3'h4 || c == 3'h6);
  endfunction : expanded

  task automatic final_report;
    if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  initial begin
    // A real edge at time zero, so the asynchronous reset takes hold
    sys_rst <= 1'b1;
    x = 1'($urandom(32'h6277));
    tick(20);
    for (int i = 0; i < 16; i++) begin
      cur = (i[3:1] == 3'h6) ? 3'($urandom % 6) : i[3:1];
      f0 = i[0];
      @(posedge core_clk);
      sys_rst <= 1'b1;
      code <= cur;
      fl <= f0;
      osc <= 1'($urandom);
      alt <= 1'b0;
      cs_req_n <= 1'b1;
      tick(8);
      cmp_byte({4'h0, cv, oe_n, cs_n, dbg}, 8'h06);
      @(posedge core_clk);
      sys_rst <= 1'b0;
      tick(2);
      cmp_byte({5'h0, mode}, {5'h0, cur});
      cmp_bit(fv, exp_flash(cur, f0));
      cmp_bit(cv, 1'b1);
      cmp_byte({4'h0, dbg, fz_t, fz_0, fz_1}, {4'h0, {4{cur == 3'h0}}});
      cmp_bit(col, osc);
      cmp_bit(pie_n, osc);
      cmp_bit(oe_n, !expanded(cur));
      // Straps moving after capture must leave the latched set alone
      @(posedge core_clk);
      code <= ~cur;
      fl <= ~f0;
      tick(6);
      cmp_byte({5'h0, mode}, {5'h0, cur});
      rd_reg(8'h00, {5'h0, cur});
      wr_reg(8'h01, {7'h0, !exp_flash(cur, f0)});
      rd_reg(8'h01, {7'h0, exp_flash(cur, f0)});
      rd_reg(8'h02, {4'h0, expanded(cur), 1'b1, osc, cur == 3'h0});
      rd_reg(8'h03 + 8'($urandom % 252), 8'h00);
      dbg_cmd(1'b0);
      cmp_bit(dbg, 1'b0);
      dbg_cmd(1'b1);
      cmp_byte({4'h0, dbg, fz_t, fz_0, fz_1}, 8'h0f);
      @(posedge core_clk);
      alt <= 1'b1;
      tick(1);
      cmp_bit(dco, 1'b1);
      dbg_cmd(1'b0);
      tick(1);
      cmp_byte({3'h0, dco, dbg, fz_t, fz_0, fz_1}, 8'h00);
      t = 3'($urandom);
      wr_reg(8'h00, {5'h0, t});
      cmp_bit(fv, exp_flash(cur, f0));
      if (!cur[2] && t != 3'h6) cur = t;
      cmp_byte({5'h0, mode}, {5'h0, cur});
      tick(1);
      cmp_bit(oe_n, !expanded(cur));
      x = 1'($urandom);
      @(posedge core_clk);
      cs_req_n <= x;
      tick(1);
      cmp_bit(cs_n, expanded(cur) ? x : 1'b1);
    end
    final_report();
  end

  initial begin
    #60000;
    err_total++;
    final_report();
  end
endmodule : tb
